// File: vcs_params.svh
// Constants for the voice codec serial port: lengths, codes, offsets
`ifndef VCS_PARAMS_SVH
`define VCS_PARAMS_SVH

// Word lengths in serial bits
`define VCS_COMP_BITS    5'h08
`define VCS_LIN_BITS     5'h10
// Standby threshold in whole frames of low frame sync
`define VCS_STBY_FRAMES  24'h000005
// Cycles of steady high receive-clock pin that select fixed rate
`define VCS_STRAP_CYCLES 8'h40
// Zero codes per companding law and for linear words
`define VCS_ZERO_MU      8'hff
`define VCS_ZERO_A       8'hd5
`define VCS_ZERO_LIN     16'h0000
// Register byte offsets
`define VCS_REG_STATUS   8'h00
`define VCS_REG_CTRL     8'h04
// Status field positions
`define VCS_ST_FIXED     0
`define VCS_ST_LINEAR    1
`define VCS_ST_ALAW      2
`define VCS_ST_RX_STBY   3
`define VCS_ST_TX_STBY   4
// Control field position and reset value
`define VCS_CTRL_MUTE    0
`define VCS_CTRL_RST     1'h0

`endif

// File: vcs_pkg.sv
// Types shared by the voice codec serial port
package vcs_pkg;

  // Filtered pin levels, one bit per pin
  typedef struct packed {
    logic master_clk;
    logic rx_bclk;
    logic tx_bclk;
    logic rx_fs;
    logic tx_fs;
    logic rx_data;
    logic coding_sel;
    logic mic_n;
  } vcs_pins_t;

  // Word handed to the expanding converter
  typedef struct packed {
    logic [15:0] data;
    logic [2:0]  gain;
    logic        linear;
    logic        alaw;
  } vcs_rx_word_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_SHIFT = 2'h1,
    RX_DONE  = 2'h3
  } vcs_rx_state_t;

  typedef enum logic {
    TX_IDLE  = 1'h0,
    TX_SHIFT = 1'h1
  } vcs_tx_state_t;

endpackage : vcs_pkg

// File: vcs_serial_port.sv
// Digital serial port of a voice-band codec with a Wishbone status port
// Contract
// - Companded words are exactly 8 bits in both directions.
// - Linear words are 16 bits: 13-bit sample then three gain/zero bits.
// - Selection pin picks the word format for both paths.
// - Companding law is fixed per variant; linear mode always available.
// - Gain bits are used only in linear mode.
// - Fixed rate: master clock also shifts transmit and receive data.
// - Variable rate: master clock never shifts serial data.
// - Receive clock pin held at supply selects fixed rate, else clocks.
// - Receive data sampled on falling edges of the active receive clock.
// - Receive path assembles one frame and hands it to the converter.
// - Transmit path shifts each converter word out serially.
// - Transmit bits driven on rising edges of the active transmit clock.
// - Channel enters standby after its frame sync is low five frames.
// - Selection pin low means linear, high means companded.
// - Mute input low forces the zero code into every transmit word.
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "vcs_params.svh"
module vcs_serial_port #(
  parameter bit ALAW_VARIANT = 1'b0
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  master_clk_i,
  input  wire logic                  rx_bit_clock_i,
  input  wire logic                  tx_bit_clock_i,
  output logic                       tx_slot_strobe_o,
  output logic                       tx_slot_strobe_oe_o,
  input  wire logic                  rx_frame_sync_i,
  input  wire logic                  tx_frame_sync_i,
  input  wire logic                  rx_data_i,
  output logic                       tx_data_o,
  output logic                       tx_data_oe_o,
  input  wire logic                  coding_select_i,
  input  wire logic                  mic_silence_n_i,
  output vcs_pkg::vcs_rx_word_t      rx_word_o,
  output logic                       rx_valid_o,
  input  wire logic [15:0]           tx_sample_i,
  output logic                       tx_taken_o,
  output logic                       rx_standby_o,
  output logic                       tx_standby_o,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // Pin synchronisers: three stages, accepted when stages two and three agree
  logic [7:0]         pin_raw;
  logic [7:0]         s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
  vcs_pkg::vcs_pins_t pin_q, pin_prev;
  assign pin_raw = {master_clk_i, rx_bit_clock_i, tx_bit_clock_i,
                    rx_frame_sync_i, tx_frame_sync_i, rx_data_i,
                    coding_select_i, mic_silence_n_i};
  always_comb filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q   <= 8'h00;
      s2_q   <= 8'h00;
      s3_q   <= 8'h00;
      filt_q <= 8'h00;
      prev_q <= 8'h00;
    end else begin
      s1_q   <= pin_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end
  assign pin_q    = filt_q;
  assign pin_prev = prev_q;

  // Edges of filtered pins
  logic mclk_rise, mclk_fall, rxclk_fall, txclk_rise, rx_fs_rise, tx_fs_rise;
  assign mclk_rise  = pin_q.master_clk & ~pin_prev.master_clk;
  assign mclk_fall  = ~pin_q.master_clk & pin_prev.master_clk;
  assign rxclk_fall = ~pin_q.rx_bclk & pin_prev.rx_bclk;
  assign txclk_rise = pin_q.tx_bclk & ~pin_prev.tx_bclk;
  assign rx_fs_rise = pin_q.rx_fs & ~pin_prev.rx_fs;
  assign tx_fs_rise = pin_q.tx_fs & ~pin_prev.tx_fs;

  // Rate strap: a receive-clock pin held high selects fixed rate
  logic [7:0] strap_cnt_q, strap_cnt_d;
  logic       fixed_q, fixed_d;
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    fixed_d     = fixed_q;
    if (!pin_q.rx_bclk) begin
      strap_cnt_d = 8'h00;
      fixed_d     = 1'b0;
    end else if (strap_cnt_q == `VCS_STRAP_CYCLES) begin
      fixed_d     = 1'b1;
    end else begin
      strap_cnt_d = strap_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_cnt_q <= 8'h00;
      fixed_q     <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      fixed_q     <= fixed_d;
    end
  end

  // Active bit clocks per rate mode
  logic rx_fall, tx_rise;
  assign rx_fall = fixed_q ? mclk_fall : rxclk_fall;
  assign tx_rise = fixed_q ? mclk_rise : txclk_rise;

  // Control register and mute
  logic ctrl_mute_q, ctrl_mute_d, mute;
  assign mute = ~pin_q.mic_n | ctrl_mute_q;

  // Frame-sync standby detectors, receive is channel 0, transmit channel 1
  logic [1:0] fs_lvl, fs_rise, stby;
  assign fs_lvl  = {pin_q.tx_fs, pin_q.rx_fs};
  assign fs_rise = {tx_fs_rise, rx_fs_rise};
  for (genvar g = 0; g < 2; g++) begin : g_stby
    logic [23:0] per_q, per_d, since_q, since_d, low_q, low_d;
    logic        stby_q, stby_d;
    // Measure frame period and low time, flag after five low frames
    always_comb begin
      per_d   = per_q;
      stby_d  = stby_q;
      since_d = (since_q == 24'hffffff) ? since_q : since_q + 24'h000001;
      low_d   = fs_lvl[g] ? 24'h000000 :
                (low_q == 24'hffffff) ? low_q : low_q + 24'h000001;
      if (fs_rise[g]) begin
        per_d   = since_q;
        since_d = 24'h000000;
        stby_d  = 1'b0;
      end else if (!fs_lvl[g] && per_q != 24'h000000 &&
                   low_q >= per_q * `VCS_STBY_FRAMES) begin
        stby_d  = 1'b1;
      end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        per_q   <= 24'h000000;
        since_q <= 24'h000000;
        low_q   <= 24'h000000;
        stby_q  <= 1'b1;
      end else begin
        per_q   <= per_d;
        since_q <= since_d;
        low_q   <= low_d;
        stby_q  <= stby_d;
      end
    end
    assign stby[g] = stby_q;
    a_stby_entry: assert property ($rose(stby_q) |->
      $past(low_q) >= $past(per_q) * `VCS_STBY_FRAMES)
      else $error("standby entered before five low frames");
  end
  assign rx_standby_o = stby[0];
  assign tx_standby_o = stby[1];

  // Receive shifter: MSB first from frame sync, word handed on completion
  vcs_pkg::vcs_rx_state_t rx_st_q, rx_st_d;
  vcs_pkg::vcs_rx_word_t  rx_word_q, rx_word_d;
  logic [15:0] rx_sr_q, rx_sr_d;
  logic [4:0]  rx_cnt_q, rx_cnt_d, rx_len;
  logic        rx_lin_q, rx_lin_d, rx_valid_q, rx_valid_d;
  assign rx_len = rx_lin_q ? `VCS_LIN_BITS : `VCS_COMP_BITS;
  always_comb begin
    rx_st_d    = rx_st_q;
    rx_sr_d    = rx_sr_q;
    rx_cnt_d   = rx_cnt_q;
    rx_lin_d   = rx_lin_q;
    rx_word_d  = rx_word_q;
    rx_valid_d = 1'b0;
    case (rx_st_q)
      vcs_pkg::RX_IDLE: begin
        if (rx_fs_rise) begin
          rx_st_d  = vcs_pkg::RX_SHIFT;
          rx_cnt_d = 5'h00;
          rx_lin_d = ~pin_q.coding_sel;
        end
      end
      vcs_pkg::RX_SHIFT: begin
        if (rx_fall) begin
          rx_sr_d  = {rx_sr_q[14:0], pin_q.rx_data};
          rx_cnt_d = rx_cnt_q + 5'h01;
          if (rx_cnt_q + 5'h01 == rx_len) begin
            rx_st_d = vcs_pkg::RX_DONE;
          end
        end
      end
      vcs_pkg::RX_DONE: begin
        rx_valid_d       = ~stby[0];
        rx_word_d.linear = rx_lin_q;
        rx_word_d.alaw   = ALAW_VARIANT;
        if (rx_lin_q) begin
          rx_word_d.data = {3'h0, rx_sr_q[15:3]};
          rx_word_d.gain = rx_sr_q[2:0];
        end else begin
          rx_word_d.data = {8'h00, rx_sr_q[7:0]};
          rx_word_d.gain = 3'h0;
        end
        rx_st_d = vcs_pkg::RX_IDLE;
      end
      default: rx_st_d = vcs_pkg::RX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st_q    <= vcs_pkg::RX_IDLE;
      rx_sr_q    <= 16'h0000;
      rx_cnt_q   <= 5'h00;
      rx_lin_q   <= 1'b0;
      rx_word_q  <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_st_q    <= rx_st_d;
      rx_sr_q    <= rx_sr_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_lin_q   <= rx_lin_d;
      rx_word_q  <= rx_word_d;
      rx_valid_q <= rx_valid_d;
    end
  end
  assign rx_word_o  = rx_word_q;
  assign rx_valid_o = rx_valid_q;

  // Transmit shifter: word loaded at frame sync, bits driven on rising edges
  vcs_pkg::vcs_tx_state_t tx_st_q, tx_st_d;
  logic [15:0] tx_sr_q, tx_sr_d, tx_zero;
  logic [4:0]  tx_cnt_q, tx_cnt_d, tx_len;
  logic        tx_lin_q, tx_lin_d, dout_q, dout_d, oe_q, oe_d;
  logic        taken_q, taken_d;
  assign tx_len  = tx_lin_q ? `VCS_LIN_BITS : `VCS_COMP_BITS;
  assign tx_zero = ~pin_q.coding_sel ? `VCS_ZERO_LIN :
                   {(ALAW_VARIANT ? `VCS_ZERO_A : `VCS_ZERO_MU), 8'h00};
  always_comb begin
    tx_st_d  = tx_st_q;
    tx_sr_d  = tx_sr_q;
    tx_cnt_d = tx_cnt_q;
    tx_lin_d = tx_lin_q;
    dout_d   = dout_q;
    oe_d     = oe_q;
    taken_d  = 1'b0;
    case (tx_st_q)
      vcs_pkg::TX_IDLE: begin
        if (tx_fs_rise) begin
          tx_st_d  = vcs_pkg::TX_SHIFT;
          tx_cnt_d = 5'h00;
          tx_lin_d = ~pin_q.coding_sel;
          taken_d  = 1'b1;
          if (mute) begin
            tx_sr_d = tx_zero;
          end else if (~pin_q.coding_sel) begin
            tx_sr_d = {tx_sample_i[12:0], 3'h0};
          end else begin
            tx_sr_d = {tx_sample_i[7:0], 8'h00};
          end
        end
      end
      vcs_pkg::TX_SHIFT: begin
        if (tx_rise) begin
          if (tx_cnt_q == tx_len) begin
            tx_st_d = vcs_pkg::TX_IDLE;
            oe_d    = 1'b0;
          end else begin
            dout_d   = tx_sr_q[15];
            tx_sr_d  = {tx_sr_q[14:0], 1'b0};
            tx_cnt_d = tx_cnt_q + 5'h01;
            oe_d     = 1'b1;
          end
        end
      end
      default: tx_st_d = vcs_pkg::TX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_q  <= vcs_pkg::TX_IDLE;
      tx_sr_q  <= 16'h0000;
      tx_cnt_q <= 5'h00;
      tx_lin_q <= 1'b0;
      dout_q   <= 1'b0;
      oe_q     <= 1'b0;
      taken_q  <= 1'b0;
    end else begin
      tx_st_q  <= tx_st_d;
      tx_sr_q  <= tx_sr_d;
      tx_cnt_q <= tx_cnt_d;
      tx_lin_q <= tx_lin_d;
      dout_q   <= dout_d;
      oe_q     <= oe_d;
      taken_q  <= taken_d;
    end
  end
  assign tx_data_o           = dout_q;
  assign tx_data_oe_o        = oe_q;
  assign tx_taken_o          = taken_q;
  assign tx_slot_strobe_o    = 1'b0; // Open drain, pulls low only
  assign tx_slot_strobe_oe_o = fixed_q & oe_q;

  // Wishbone slave: ack one cycle after request, dropped the cycle after
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  always_comb begin
    ack_d       = wb_cyc_i & wb_stb_i & ~ack_q;
    rdat_d      = 32'h00000000;
    ctrl_mute_d = ctrl_mute_q;
    if (ack_d && !wb_we_i) begin
      case (wb_adr_i)
        `VCS_REG_STATUS: begin
          rdat_d[`VCS_ST_FIXED]   = fixed_q;
          rdat_d[`VCS_ST_LINEAR]  = ~pin_q.coding_sel;
          rdat_d[`VCS_ST_ALAW]    = ALAW_VARIANT;
          rdat_d[`VCS_ST_RX_STBY] = stby[0];
          rdat_d[`VCS_ST_TX_STBY] = stby[1];
        end
        `VCS_REG_CTRL: rdat_d[`VCS_CTRL_MUTE] = ctrl_mute_q;
        default: rdat_d = 32'h00000000;
      endcase
    end
    if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == `VCS_REG_CTRL) begin
      ctrl_mute_d = wb_dat_i[`VCS_CTRL_MUTE];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q       <= 1'b0;
      rdat_q      <= 32'h00000000;
      ctrl_mute_q <= `VCS_CTRL_RST;
    end else begin
      ack_q       <= ack_d;
      rdat_q      <= rdat_d;
      ctrl_mute_q <= ctrl_mute_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Checks on word format, clocking and muting
  a_rx_word_len: assert property (rx_st_q == vcs_pkg::RX_DONE |->
    rx_cnt_q == (rx_lin_q ? 5'h10 : 5'h08))
    else $error("receive word length wrong");
  a_tx_pad_zero: assert property (tx_st_q == vcs_pkg::TX_IDLE && tx_fs_rise
    && ~pin_q.coding_sel |=> tx_sr_q[2:0] == 3'h0)
    else $error("linear transmit padding not zero");
  a_rx_format_pin: assert property (rx_st_q == vcs_pkg::RX_IDLE && rx_fs_rise
    |=> rx_lin_q == !$past(pin_q.coding_sel))
    else $error("receive format not taken from pin");
  a_gain_companded: assert property (rx_valid_o && !rx_word_o.linear |->
    rx_word_o.gain == 3'h0 && rx_word_o.data[15:8] == 8'h00)
    else $error("gain bits seen in companded mode");
  a_strap_low: assert property (!pin_q.rx_bclk |=> !fixed_q)
    else $error("fixed rate kept with clock pin low");
  a_var_no_mclk: assert property (!fixed_q && rx_st_q == vcs_pkg::RX_SHIFT &&
    !rxclk_fall |=> $stable(rx_sr_q))
    else $error("receive shifted without receive clock");
  a_fixed_mclk: assert property (fixed_q && rx_st_q == vcs_pkg::RX_SHIFT &&
    mclk_fall |=> rx_sr_q[0] == $past(pin_q.rx_data))
    else $error("master clock edge did not shift receive data");
  a_tx_on_rise: assert property ($changed(dout_q) |-> $past(tx_rise))
    else $error("transmit bit changed off a rising clock edge");
  a_tx_mute_zero: assert property (tx_st_q == vcs_pkg::TX_IDLE && tx_fs_rise
    && mute |=> tx_sr_q == $past(tx_zero))
    else $error("muted word not zero code");
  a_rx_hand_over: assert property (rx_st_q == vcs_pkg::RX_DONE && !stby[0]
    |=> rx_valid_o ##1 !rx_valid_o)
    else $error("receive word not handed on once");

  c_rx_linear: cover property (rx_valid_o && rx_word_o.linear);
  c_rx_comp: cover property (rx_valid_o && !rx_word_o.linear);
  c_tx_muted: cover property (taken_q && mute);
  c_rx_standby: cover property ($rose(stby[0]));

endmodule : vcs_serial_port

// File: vcs_dsp_model.sv
// Signal-processor model driving clocks, frame syncs and receive data
`timescale 1ns/100ps
module vcs_dsp_model (
  input  wire logic sys_clk_i,
  input  wire logic fixed_i,
  input  wire logic strobe_i,
  input  wire logic strobe_oe_i,
  input  wire logic tx_data_i,
  output logic      master_clk_o,
  output logic      rx_bclk_o,
  output logic      tx_bclk_o,
  output logic      rx_fs_o,
  output logic      tx_fs_o,
  output logic      rx_data_o
);
  logic [2:0] ph_q = 3'h0;
  logic [3:0] mph_q = 4'h0;
  logic       en_q = 1'b0;
  logic       fs_q = 1'b0;
  logic       dat_q = 1'b0;
  int         cyc_n = 0;
  int         last_rise = -10000;

  // Free phase counters: bit clock 200 ns, master clock 400 ns at variable rate and 200 ns at fixed rate
  always @(posedge sys_clk_i) begin
    ph_q  <= ph_q + 3'h1;
    mph_q <= mph_q + 4'h1;
    cyc_n <= cyc_n + 1;
  end

  // Nearest master rate to the nominal one that the bench clock allows
  assign master_clk_o = fixed_i ? ~ph_q[2] : ~mph_q[3];
  // At variable rate, bit clocks stand still low outside frames; fixed rate holds the receive clock high
  assign rx_bclk_o = fixed_i ? 1'b1 : (~ph_q[2] & en_q);
  // Open-drain strobe has a pull-up when released
  assign tx_bclk_o = fixed_i ? ~(strobe_oe_i & ~strobe_i)
                             : (~ph_q[2] & en_q);
  assign rx_fs_o   = fs_q;
  assign tx_fs_o   = fs_q;
  assign rx_data_o = dat_q;

  // One full-duplex frame: data changes on rises, captured before rises
  task automatic frame(input logic [15:0] w, input int n,
                       output logic [15:0] got, output logic seen);
    got = 16'h0000;
    seen = 1'b0;
    while (cyc_n - last_rise < 2500) @(posedge sys_clk_i);
    do @(posedge sys_clk_i); while (ph_q != 3'h5);
    last_rise = cyc_n;
    fs_q  <= 1'b1;
    en_q  <= 1'b1;
    dat_q <= w[n-1];
    repeat (2) @(posedge sys_clk_i);
    for (int k = 0; k <= n; k++) begin
      if (k > 0) begin
        got = {got[14:0], tx_data_i};
        seen = seen | strobe_oe_i;
      end
      if (k < n) begin
        dat_q <= w[n-1-k];
        repeat (8) @(posedge sys_clk_i);
      end
    end
    repeat (5) @(posedge sys_clk_i);
    en_q  <= 1'b0;
    fs_q  <= 1'b0;
    dat_q <= ~dat_q; // Released line shows no stale value
  endtask : frame
endmodule : vcs_dsp_model

// File: tb.sv
// Self-checking bench for the voice codec serial port
`timescale 1ns/100ps
module tb;
  logic                  sys_clk = 1'b0;
  logic                  rstn;
  logic                  fixed;
  logic                  coding;
  logic                  mic_n;
  logic [15:0]           tx_sample;
  logic                  wb_cyc;
  logic                  wb_stb;
  logic                  wb_we;
  logic [7:0]            wb_adr;
  logic [3:0]            wb_sel;
  logic [31:0]           wb_wdat;
  logic [31:0]           wb_rdat;
  logic                  wb_ack;
  logic                  mclk;
  logic                  rx_bclk;
  logic                  tx_bclk;
  logic                  rx_fs;
  logic                  tx_fs;
  logic                  rx_data;
  logic                  strobe;
  logic                  strobe_oe;
  logic                  tx_data;
  logic                  tx_oe;
  logic                  rx_valid;
  logic                  tx_taken;
  logic                  rx_stby;
  logic                  tx_stby;
  vcs_pkg::vcs_rx_word_t rx_word;
  vcs_pkg::vcs_rx_word_t rx_last;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  int                    rx_cnt = 0;
  int                    tx_cnt = 0;
  int                    cycles = 0;

  vcs_serial_port #(.ALAW_VARIANT(1'b0)) DUT (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .master_clk_i(mclk),
    .rx_bit_clock_i(rx_bclk), .tx_bit_clock_i(tx_bclk),
    .tx_slot_strobe_o(strobe), .tx_slot_strobe_oe_o(strobe_oe),
    .rx_frame_sync_i(rx_fs), .tx_frame_sync_i(tx_fs),
    .rx_data_i(rx_data), .tx_data_o(tx_data), .tx_data_oe_o(tx_oe),
    .coding_select_i(coding), .mic_silence_n_i(mic_n),
    .rx_word_o(rx_word), .rx_valid_o(rx_valid),
    .tx_sample_i(tx_sample), .tx_taken_o(tx_taken),
    .rx_standby_o(rx_stby), .tx_standby_o(tx_stby),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack)
  );

  vcs_dsp_model dsp (
    .sys_clk_i(sys_clk), .fixed_i(fixed), .strobe_i(strobe),
    .strobe_oe_i(strobe_oe), .tx_data_i(tx_data),
    .master_clk_o(mclk), .rx_bclk_o(rx_bclk), .tx_bclk_o(tx_bclk),
    .rx_fs_o(rx_fs), .tx_fs_o(tx_fs), .rx_data_o(rx_data)
  );

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  // Word and load monitors, hang limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1) begin
      rx_cnt  <= rx_cnt + 1;
      rx_last <= rx_word;
    end
    if (tx_taken === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
    end
    if (cycles == 50000) begin
      n_mismatch++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // Classic single Wishbone cycle, held until ack is sampled
  task wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
               output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_adr  <= a;
    wb_we   <= w;
    wb_wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    if (n >= 20) n_mismatch++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_xfer

  task wb_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(a, 1'b0, 32'h0, q);
    chk_word(q, exp);
  endtask : wb_rd

  task wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, d, q);
  endtask : wb_wr

  // One duplex frame with pin setup and checks of both directions
  task run(input logic cod, input logic mic, input logic [15:0] rxw,
           input logic [15:0] smp, input logic [15:0] exp_tx,
           input logic [15:0] exp_dat, input logic [2:0] exp_gain,
           input logic exp_oe);
    logic [15:0] got;
    logic        seen;
    int          r0;
    int          t0;
    coding    <= cod;
    mic_n     <= mic;
    tx_sample <= smp;
    repeat (8) @(posedge sys_clk);
    r0 = rx_cnt;
    t0 = tx_cnt;
    dsp.frame(rxw, cod ? 8 : 16, got, seen);
    repeat (4) @(posedge sys_clk);
    chk_word({16'h0000, got}, {16'h0000, exp_tx});
    chk_word(rx_cnt - r0, 32'h1);
    chk_word(tx_cnt - t0, 32'h1);
    chk_word({16'h0000, rx_last.data}, {16'h0000, exp_dat});
    chk_word({29'h0, rx_last.gain}, {29'h0, exp_gain});
    chk_flag(rx_last.linear, ~cod);
    chk_flag(rx_last.alaw, 1'b0);
    chk_flag(seen, exp_oe);
    chk_flag(tx_oe, 1'b0);
    chk_flag(strobe, 1'b0);
  endtask : run

  // Main sequence
  initial begin
    rstn = 1'b0;
    fixed = 1'b0;
    coding = 1'b1;
    mic_n = 1'b1;
    tx_sample = 16'h0000;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_wdat = 32'h0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk_flag(rx_stby, 1'b1);
    chk_flag(tx_stby, 1'b1);
    repeat (100) @(posedge sys_clk);
    wb_rd(8'h00, 32'h18);
    wb_rd(8'h08, 32'h0);
    wb_wr(8'h04, 32'h1);
    wb_rd(8'h04, 32'h1);
    run(1, 1, 16'h00a5, 16'h003c, 16'h00ff, 16'h00a5, 3'h0, 0);
    wb_wr(8'h04, 32'h0);
    wb_rd(8'h04, 32'h0);
    run(1, 1, 16'h005a, 16'hff3c, 16'h003c, 16'h005a, 3'h0, 0);
    run(0, 1, 16'hd5e5, 16'hef0f, 16'h7878, 16'h1abc, 3'h5, 0);
    wb_rd(8'h00, 32'h02);
    run(0, 0, 16'hfff8, 16'h1234, 16'h0000, 16'h1fff, 3'h0, 0);
    run(1, 0, 16'h0080, 16'h0055, 16'h00ff, 16'h0080, 3'h0, 0);
    chk_flag(rx_stby, 1'b0);
    repeat (7000) @(posedge sys_clk);
    chk_flag(rx_stby, 1'b0);
    chk_flag(tx_stby, 1'b0);
    repeat (8000) @(posedge sys_clk);
    chk_flag(rx_stby, 1'b1);
    chk_flag(tx_stby, 1'b1);
    fixed <= 1'b1;
    repeat (200) @(posedge sys_clk);
    wb_rd(8'h00, 32'h19);
    run(1, 1, 16'h0096, 16'h0069, 16'h0069, 16'h0096, 3'h0, 1);
    wb_rd(8'h00, 32'h01);
    summarize();
  end
endmodule : tb
